// ==== src/servo_homing_sequencer.v ====
// Homing sequencer: limit, reference and index driven homing methods 1 to 14
`timescale 1ns/10ps
`default_nettype none
`include "servo_homing_consts.vh"
// Operation
// R1 - Method 1: negative limit, return to index
// R2 - Method 2 mirrors method 1, positive limit
// R3 - Method 3, reference low: fast positive, return
// R4 - Method 3, reference high: slow negative to index
// R5 - Method 4, reference low: slow positive to index
// R6 - Method 4, reference high: fast negative, return
// R7 - Method 5, reference high: slow positive to index
// R8 - Method 5, reference low: fast negative, return
// R9 - Method 6, reference high: fast positive, return
// R10 - Method 6, reference low: slow negative to index
// R11 - Methods 7 to 10 start positive; methods 7 and 8 start negative when reference is high
// R12 - Method 7 normal and reference-high branches
// R13 - Method 7 limit met: reverse, stop past fall
// R14 - Method 8 normal and reference-high branches
// R15 - Method 8 limit met: reverse, return positive
// R16 - Method 9 normal branch, three segments
// R17 - Method 9 reference high: positive, reverse
// R18 - Method 9 limit met: reverse, slow, index
// R19 - Method 10 normal and reference-high branches
// R20 - Method 10 limit met: reverse, return positive
// R21 - Methods 11 to 14 mirror 7 to 10
// R22 - Fast and slow speed select per segment
// R23 - Sample levels at enable, stop on completion
// R24 - Only first index after edge qualifies

module servo_homing_sequencer
(
   // Clock and reset
   input wire CLK,
   input wire RESET,
   // Homing command
   input wire HOME_ENABLE,
   input wire [3:0] HOME_METHOD,
   // Switches and encoder
   input wire NEG_LIMIT,
   input wire POS_LIMIT,
   input wire HOME_REF,
   input wire INDEX_PULSE,
   // Motion profile commands
   output reg MOVE_ACTIVE,
   output reg MOVE_POSITIVE,
   output reg SPEED_FAST,
   output reg STOP_REQ,
   output reg HOMING_DONE,
   output reg METHOD_ERROR
);

   localparam ST_IDLE = 2'H0;
   localparam ST_RUN = 2'H1;
   localparam ST_DONE = 2'H2;

   ////////////////////////////////////////////////////////////////////////
   // Segment table for canonical methods 1 and 3 to 10
   function [6:0] seg_of;
      input [3:0] m;
      input [1:0] b;
      input [1:0] p;
      begin
         case ({m, b, p})
            {4'H1, `BR_A, 2'H0}: seg_of = {1'B0, 1'B1, `EV_LIM_RISE, 1'B0, 1'B0}; // R1
            {4'H1, `BR_A, 2'H1}: seg_of = {1'B1, 1'B0, `EV_LIM_FALL, 1'B1, 1'B1}; // R1
            {4'H1, `BR_B, 2'H0}: seg_of = {1'B1, 1'B0, `EV_LIM_FALL, 1'B1, 1'B1}; // R1
            {4'H3, `BR_A, 2'H0}: seg_of = {1'B1, 1'B1, `EV_REF_RISE, 1'B1, 1'B0}; // R3
            {4'H3, `BR_A, 2'H1}: seg_of = {1'B0, 1'B0, `EV_REF_FALL, 1'B1, 1'B1}; // R3
            {4'H3, `BR_B, 2'H0}: seg_of = {1'B0, 1'B0, `EV_REF_FALL, 1'B1, 1'B1}; // R4
            {4'H4, `BR_A, 2'H0}: seg_of = {1'B1, 1'B0, `EV_REF_FALL, 1'B1, 1'B1}; // R5
            {4'H4, `BR_B, 2'H0}: seg_of = {1'B0, 1'B1, `EV_REF_FALL, 1'B1, 1'B0}; // R6
            {4'H4, `BR_B, 2'H1}: seg_of = {1'B1, 1'B0, `EV_REF_RISE, 1'B1, 1'B1}; // R6
            {4'H5, `BR_B, 2'H0}: seg_of = {1'B1, 1'B0, `EV_REF_FALL, 1'B1, 1'B1}; // R7
            {4'H5, `BR_A, 2'H0}: seg_of = {1'B0, 1'B1, `EV_REF_RISE, 1'B1, 1'B0}; // R8
            {4'H5, `BR_A, 2'H1}: seg_of = {1'B1, 1'B0, `EV_REF_FALL, 1'B1, 1'B1}; // R8
            {4'H6, `BR_B, 2'H0}: seg_of = {1'B1, 1'B1, `EV_REF_FALL, 1'B1, 1'B0}; // R9
            {4'H6, `BR_B, 2'H1}: seg_of = {1'B0, 1'B0, `EV_REF_FALL, 1'B1, 1'B1}; // R9
            {4'H6, `BR_A, 2'H0}: seg_of = {1'B0, 1'B0, `EV_REF_RISE, 1'B1, 1'B1}; // R10
            {4'H7, `BR_A, 2'H0}: seg_of = {1'B1, 1'B1, `EV_REF_RISE, 1'B0, 1'B0}; // R12
            {4'H7, `BR_A, 2'H1}: seg_of = {1'B0, 1'B0, `EV_REF_FALL, 1'B1, 1'B1}; // R12
            {4'H7, `BR_B, 2'H0}: seg_of = {1'B0, 1'B0, `EV_REF_FALL, 1'B1, 1'B1}; // R12
            {4'H7, `BR_C, 2'H0}: seg_of = {1'B0, 1'B1, `EV_REF_RISE, 1'B0, 1'B0}; // R13
            {4'H7, `BR_C, 2'H1}: seg_of = {1'B0, 1'B0, `EV_REF_FALL, 1'B1, 1'B1}; // R13
            {4'H8, `BR_A, 2'H0}: seg_of = {1'B1, 1'B1, `EV_REF_RISE, 1'B0, 1'B0}; // R14
            {4'H8, `BR_A, 2'H1}: seg_of = {1'B1, 1'B0, `EV_NONE, 1'B1, 1'B1}; // R14
            {4'H8, `BR_B, 2'H0}: seg_of = {1'B0, 1'B0, `EV_REF_FALL, 1'B0, 1'B0}; // R14
            {4'H8, `BR_B, 2'H1}: seg_of = {1'B1, 1'B0, `EV_REF_RISE, 1'B1, 1'B1}; // R14
            {4'H8, `BR_C, 2'H0}: seg_of = {1'B0, 1'B1, `EV_REF_RISE, 1'B0, 1'B0}; // R15
            {4'H8, `BR_C, 2'H1}: seg_of = {1'B0, 1'B0, `EV_REF_FALL, 1'B0, 1'B0}; // R15
            {4'H8, `BR_C, 2'H2}: seg_of = {1'B1, 1'B0, `EV_REF_RISE, 1'B1, 1'B1}; // R15
            {4'H9, `BR_A, 2'H0}: seg_of = {1'B1, 1'B1, `EV_REF_RISE, 1'B0, 1'B0}; // R16
            {4'H9, `BR_A, 2'H1}: seg_of = {1'B1, 1'B0, `EV_REF_FALL, 1'B0, 1'B0}; // R16
            {4'H9, `BR_A, 2'H2}: seg_of = {1'B0, 1'B0, `EV_REF_RISE, 1'B1, 1'B1}; // R16
            {4'H9, `BR_B, 2'H0}: seg_of = {1'B1, 1'B0, `EV_REF_FALL, 1'B0, 1'B0}; // R17
            {4'H9, `BR_B, 2'H1}: seg_of = {1'B0, 1'B0, `EV_REF_RISE, 1'B1, 1'B1}; // R17
            {4'H9, `BR_C, 2'H0}: seg_of = {1'B0, 1'B1, `EV_REF_RISE, 1'B0, 1'B0}; // R18
            {4'H9, `BR_C, 2'H1}: seg_of = {1'B0, 1'B0, `EV_NONE, 1'B1, 1'B1}; // R18
            {4'HA, `BR_A, 2'H0}: seg_of = {1'B1, 1'B1, `EV_REF_RISE, 1'B0, 1'B0}; // R19
            {4'HA, `BR_A, 2'H1}: seg_of = {1'B1, 1'B0, `EV_REF_FALL, 1'B1, 1'B1}; // R19
            {4'HA, `BR_B, 2'H0}: seg_of = {1'B1, 1'B0, `EV_REF_FALL, 1'B1, 1'B1}; // R19
            {4'HA, `BR_C, 2'H0}: seg_of = {1'B0, 1'B1, `EV_REF_RISE, 1'B0, 1'B0}; // R20
            {4'HA, `BR_C, 2'H1}: seg_of = {1'B1, 1'B0, `EV_REF_FALL, 1'B1, 1'B1}; // R20
            default: seg_of = 7'H00;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers for all pin inputs
   reg [8:0] sync1_r;
   reg [8:0] sync2_r;
   reg [4:0] prev_r;

   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         sync1_r <= 9'H000;
         sync2_r <= 9'H000;
         prev_r <= 5'H00;
      end
      else
      begin
         sync1_r <= {HOME_METHOD, HOME_ENABLE, NEG_LIMIT, POS_LIMIT, HOME_REF, INDEX_PULSE};
         sync2_r <= sync1_r;
         prev_r <= sync2_r[4:0];
      end
   end

   wire [3:0] method_s = sync2_r[8:5];
   wire enable_s = sync2_r[4];
   wire neg_s = sync2_r[3];
   wire pos_s = sync2_r[2];
   wire ref_s = sync2_r[1];
   wire index_rise = sync2_r[0] & ~prev_r[0];
   wire enable_rise = enable_s & ~prev_r[4];
   wire ref_rise = ref_s & ~prev_r[1];
   wire ref_fall = ~ref_s & prev_r[1];

   ////////////////////////////////////////////////////////////////////////
   // Sequencer state
   reg [1:0] st_r;
   reg [1:0] st_nxt;
   reg [3:0] can_r;
   reg [3:0] can_nxt;
   reg mirror_r;
   reg mirror_nxt;
   reg [1:0] br_r;
   reg [1:0] br_nxt;
   reg [1:0] ph_r;
   reg [1:0] ph_nxt;
   reg armed_r;
   reg armed_nxt;
   reg err_nxt;

   // Methods 2 and 11 to 14 run a canonical table with directions swapped
   wire start_mirror = (method_s == 4'H2) || (method_s >= `METHOD_MIRROR_BASE); // R2 R21
   wire [3:0] start_can = (method_s == 4'H2) ? 4'H1 :
      (method_s >= `METHOD_MIRROR_BASE) ? (method_s - `METHOD_MIRROR_SHIFT) : method_s;
   wire method_ok = (method_s >= `METHOD_FIRST) && (method_s <= `METHOD_LAST);

   // Limit watched: method 1 looks negative, methods 7 to 10 positive, swapped when mirrored
   wire lim_pos_start = (start_can == 4'H1) ? start_mirror : ~start_mirror;
   wire lim_pos_cur = (can_r == 4'H1) ? mirror_r : ~mirror_r;
   wire lim_cur = lim_pos_cur ? pos_s : neg_s;
   wire lim_prev = lim_pos_cur ? prev_r[2] : prev_r[3];
   wire lim_rise = lim_cur & ~lim_prev;
   wire lim_fall = ~lim_cur & lim_prev;

   // Branch chosen from the level of the switch that the method starts on
   wire start_level = (start_can == 4'H1) ? (lim_pos_start ? pos_s : neg_s) : ref_s; // R23

   wire [6:0] seg = seg_of(can_r, br_r, ph_r);
   wire [2:0] seg_ev = seg[`SEG_EV_HI:`SEG_EV_LO];
   reg ev_hit;

   // Segment end event decode
   always @*
   begin
      case (seg_ev)
         `EV_REF_RISE: ev_hit = ref_rise;
         `EV_REF_FALL: ev_hit = ref_fall;
         `EV_LIM_RISE: ev_hit = lim_rise;
         `EV_LIM_FALL: ev_hit = lim_fall;
         default: ev_hit = 1'B0;
      endcase
   end

   // Index counts only once armed, never in the cycle that arms it
   wire idx_ok = armed_r & index_rise; // R24
   wire seg_end = seg[`SEG_IDX] ? idx_ok : ev_hit;

   // Next-state logic
   always @*
   begin
      st_nxt = st_r;
      can_nxt = can_r;
      mirror_nxt = mirror_r;
      br_nxt = br_r;
      ph_nxt = ph_r;
      armed_nxt = armed_r;
      err_nxt = METHOD_ERROR;
      case (st_r)
         ST_IDLE:
         begin
            if (enable_rise)
            begin
               err_nxt = ~method_ok;
               st_nxt = method_ok ? ST_RUN : ST_DONE;
               can_nxt = start_can;
               mirror_nxt = start_mirror;
               br_nxt = start_level ? `BR_B : `BR_A; // R23
               ph_nxt = `RST_PHASE;
               armed_nxt = 1'B0;
            end
         end
         ST_RUN:
         begin
            if (!enable_s)
            begin
               st_nxt = ST_IDLE;
            end
            else if ((can_r >= `METHOD_LIMIT_REF_FIRST) && (br_r == `BR_A) &&
               (ph_r == `RST_PHASE) && lim_rise)
            begin
               // Limit met on the way out: reverse fast along branch C
               br_nxt = `BR_C; // R13 R15 R18 R20
               armed_nxt = 1'B0;
            end
            else if (seg_end)
            begin
               armed_nxt = 1'B0; // R24
               if (seg[`SEG_LAST])
               begin
                  st_nxt = ST_DONE; // R23
               end
               else
               begin
                  ph_nxt = ph_r + 2'H1;
               end
            end
            else if (seg[`SEG_IDX] && (ev_hit || (seg_ev == `EV_NONE)))
            begin
               armed_nxt = 1'B1; // R24
            end
         end
         ST_DONE:
         begin
            if (!enable_s)
            begin
               st_nxt = ST_IDLE;
               err_nxt = 1'B0;
            end
         end
         default:
         begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   wire [6:0] seg_n = seg_of(can_nxt, br_nxt, ph_nxt);

   ////////////////////////////////////////////////////////////////////////
   // State and registered outputs; commands follow the next segment so they
   // change in the same edge as the state, with no extra cycle of lag
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         st_r <= ST_IDLE;
         can_r <= `RST_METHOD;
         mirror_r <= 1'B0;
         br_r <= `BR_A;
         ph_r <= `RST_PHASE;
         armed_r <= 1'B0;
         MOVE_ACTIVE <= 1'B0;
         MOVE_POSITIVE <= 1'B0;
         SPEED_FAST <= 1'B0;
         STOP_REQ <= 1'B1;
         HOMING_DONE <= 1'B0;
         METHOD_ERROR <= 1'B0;
      end
      else
      begin
         st_r <= st_nxt;
         can_r <= can_nxt;
         mirror_r <= mirror_nxt;
         br_r <= br_nxt;
         ph_r <= ph_nxt;
         armed_r <= armed_nxt;
         MOVE_ACTIVE <= (st_nxt == ST_RUN);
         MOVE_POSITIVE <= (st_nxt == ST_RUN) & (seg_n[`SEG_DIR] ^ mirror_nxt); // R11 R21
         SPEED_FAST <= (st_nxt == ST_RUN) & seg_n[`SEG_FAST]; // R22
         STOP_REQ <= (st_nxt != ST_RUN); // R23
         HOMING_DONE <= (st_nxt == ST_DONE) & ~err_nxt; // R23
         METHOD_ERROR <= err_nxt;
      end
   end

endmodule
`default_nettype wire

// ==== common/servo_homing_consts.vh ====
// Constants for the servo homing sequencer
`ifndef SERVO_HOMING_CONSTS_VH
`define SERVO_HOMING_CONSTS_VH

// Legal method range handled here
`define METHOD_FIRST 4'H1
`define METHOD_LAST 4'HE
`define METHOD_MIRROR_BASE 4'HB
`define METHOD_MIRROR_SHIFT 4'H4
`define METHOD_LIMIT_REF_FIRST 4'H7

// Branch selected at start (A: sampled input low, B: high); C taken later while running, when the limit is met
`define BR_A 2'H0
`define BR_B 2'H1
`define BR_C 2'H2

// Segment end events
`define EV_REF_RISE 3'H0
`define EV_REF_FALL 3'H1
`define EV_LIM_RISE 3'H2
`define EV_LIM_FALL 3'H3
`define EV_NONE 3'H4

// Segment descriptor bit positions {dir, fast, ev[2:0], idx, last}
`define SEG_DIR 6
`define SEG_FAST 5
`define SEG_EV_HI 4
`define SEG_EV_LO 2
`define SEG_IDX 1
`define SEG_LAST 0

// Reset values
`define RST_PHASE 2'H0
`define RST_METHOD 4'H0

`endif

// ==== sim/servo_homing_checker.sv ====
// Port assertions for the homing sequencer
`timescale 1ns/10ps
`default_nettype none
module servo_homing_checker
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Command and switches
   input wire logic HOME_ENABLE,
   input wire logic [3:0] HOME_METHOD,
   input wire logic NEG_LIMIT,
   input wire logic HOME_REF,
   input wire logic INDEX_PULSE,
   // Motion commands
   input wire logic MOVE_ACTIVE,
   input wire logic MOVE_POSITIVE,
   input wire logic SPEED_FAST,
   input wire logic STOP_REQ,
   input wire logic HOMING_DONE,
   input wire logic METHOD_ERROR
);
default clocking @(posedge CLK); endclocking
default disable iff (RESET);
logic [3:0] gap_r;
// Age of the last index, saturating so it never wraps to a false match
always @(posedge CLK or posedge RESET)
   if (RESET)
      gap_r <= 4'HF;
   else if (INDEX_PULSE)
      gap_r <= 4'H0;
   else if (gap_r != 4'HF)
      gap_r <= gap_r + 4'H1;
////////////////////////////////////////////////////////////
// Fresh start: enable low three samples, then high
sequence s_go;
   !HOME_ENABLE [*3] ##1 HOME_ENABLE;
endsequence
a_run_clear: assert property (MOVE_ACTIVE |-> !STOP_REQ)
   else $error("stop request while moving");
a_done_halt: assert property (HOMING_DONE |-> STOP_REQ && !MOVE_ACTIVE)
   else $error("done while moving");
a_idle_zero: assert property (!MOVE_ACTIVE |-> !MOVE_POSITIVE && !SPEED_FAST)
   else $error("direction or speed left set while idle");
a_start_moves: assert property (s_go ##0 HOME_METHOD inside {[1:14]} |-> ##[2:4] MOVE_ACTIVE)
   else $error("no motion after start");
a_bad_method: assert property (s_go ##0 HOME_METHOD inside {0, 15} |-> ##[2:4] METHOD_ERROR)
   else $error("bad method not flagged");
a_m1_first: assert property (s_go ##0 HOME_METHOD == 4'H1 && !NEG_LIMIT
   |-> ##[2:4] MOVE_ACTIVE && !MOVE_POSITIVE && SPEED_FAST) else $error("method 1 start wrong");
a_fwd_first: assert property (s_go ##0 HOME_METHOD inside {[7:10]} && !HOME_REF
   |-> ##[2:4] MOVE_ACTIVE && MOVE_POSITIVE && SPEED_FAST) else $error("start not positive");
a_mirror_first: assert property (s_go ##0 HOME_METHOD inside {[11:14]} && !HOME_REF
   |-> ##[2:4] MOVE_ACTIVE && !MOVE_POSITIVE && SPEED_FAST) else $error("start not negative");
a_index_stop: assert property ($rose(HOMING_DONE) |-> gap_r inside {[1:6]})
   else $error("done without a recent index");
a_abort_clear: assert property ($fell(HOME_ENABLE) |-> ##[2:5] !HOMING_DONE && !METHOD_ERROR)
   else $error("flags kept after enable fell");
endmodule
bind servo_homing_sequencer servo_homing_checker chk
(
   .CLK(CLK), .RESET(RESET), .HOME_ENABLE(HOME_ENABLE), .HOME_METHOD(HOME_METHOD),
   .NEG_LIMIT(NEG_LIMIT), .HOME_REF(HOME_REF), .INDEX_PULSE(INDEX_PULSE),
   .MOVE_ACTIVE(MOVE_ACTIVE), .MOVE_POSITIVE(MOVE_POSITIVE), .SPEED_FAST(SPEED_FAST),
   .STOP_REQ(STOP_REQ), .HOMING_DONE(HOMING_DONE), .METHOD_ERROR(METHOD_ERROR)
);
`default_nettype wire

// ==== sim/servo_motor_model.sv ====
// Axis model: position, limit and reference switches, encoder index
`timescale 1ns/10ps
`default_nettype none
module servo_motor_model
(
   // Clock and start position
   input wire logic clk,
   input wire logic load,
   input wire logic [15:0] load_pos,
   // Motion commands
   input wire logic move_active,
   input wire logic move_positive,
   input wire logic speed_fast,
   // Switches and encoder
   output logic neg_limit,
   output logic pos_limit,
   output logic home_ref,
   output logic index_pulse,
   output logic [15:0] last_idx
);
logic [15:0] pos_r = 16'H03E8;
logic [15:0] pos_nxt;
logic [15:0] step;
// Limits at the ends, reference over a window mid-travel only
assign neg_limit = pos_r < 16'H0096;
assign pos_limit = pos_r > 16'H073A;
assign home_ref = pos_r >= 16'H03B6 && pos_r < 16'H041A;
initial
begin
   index_pulse = 1'H0;
   last_idx = 16'H0000;
end
// Fast moves four units a cycle, so every stop overshoots like a real axis
always @(negedge clk)
begin
   step = speed_fast ? 16'H0004 : 16'H0001;
   pos_nxt = !move_active ? pos_r : move_positive ? pos_r + step : pos_r - step;
   // Index mark every 100 units, one cycle wide
   index_pulse <= !load && pos_nxt / 16'H0064 != pos_r / 16'H0064;
   if (load)
      last_idx <= 16'H0000;
   else if (pos_nxt / 16'H0064 != pos_r / 16'H0064)
      last_idx <= (pos_nxt > pos_r ? pos_nxt : pos_r) / 16'H0064 * 16'H0064;
   pos_r <= load ? load_pos : pos_nxt;
end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench: homing methods run against the axis model
`timescale 1ns/10ps
`default_nettype none
module testbench;
logic CLK = 1'H0;
logic RESET = 1'H1;
logic HOME_ENABLE = 1'H0;
logic [3:0] HOME_METHOD = 4'H1;
logic load = 1'H1;
logic [15:0] load_pos = 16'H03E8;
logic [15:0] last_idx;
logic [7:0] lfsr = 8'H52;
logic done_prev = 1'H0;
logic [15:0] exp_q[$];
int bad_count = 0;
int checked = 0;
int cycles = 0;
wire NEG_LIMIT, POS_LIMIT, HOME_REF, INDEX_PULSE, MOVE_ACTIVE, MOVE_POSITIVE;
wire SPEED_FAST, STOP_REQ, HOMING_DONE, METHOD_ERROR;
always #4 CLK = ~CLK;
servo_homing_sequencer dut
(
   .CLK(CLK), .RESET(RESET), .HOME_ENABLE(HOME_ENABLE), .HOME_METHOD(HOME_METHOD),
   .NEG_LIMIT(NEG_LIMIT), .POS_LIMIT(POS_LIMIT), .HOME_REF(HOME_REF),
   .INDEX_PULSE(INDEX_PULSE), .MOVE_ACTIVE(MOVE_ACTIVE), .MOVE_POSITIVE(MOVE_POSITIVE),
   .SPEED_FAST(SPEED_FAST), .STOP_REQ(STOP_REQ), .HOMING_DONE(HOMING_DONE),
   .METHOD_ERROR(METHOD_ERROR)
);
servo_motor_model motor
(
   .clk(CLK), .load(load), .load_pos(load_pos), .move_active(MOVE_ACTIVE),
   .move_positive(MOVE_POSITIVE), .speed_fast(SPEED_FAST), .neg_limit(NEG_LIMIT),
   .pos_limit(POS_LIMIT), .home_ref(HOME_REF), .index_pulse(INDEX_PULSE), .last_idx(last_idx)
);
////////////////////////////////////////////////////////////
function automatic logic [7:0] lfsr_next(input logic [7:0] v);
   return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
endfunction
task conclude;
   $display("Mismatches %0d, comparisons %0d", bad_count, checked);
   if (bad_count == 0 && checked > 0)
      $display("Test passed");
   else
      $display("Test failed");
   $finish;
endtask
task cmp(input logic [15:0] got, input logic [15:0] exp);
   checked++;
   if (got !== exp)
   begin
      bad_count++;
      $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
   end
endtask
// One homing run from a jittered start; the stop index is noted up front
task run(input logic [3:0] m, input logic [15:0] s, input logic [15:0] e);
   int n;
   lfsr = lfsr_next(lfsr);
   @(negedge CLK);
   load = 1'H1;
   load_pos = s + {13'H0000, lfsr[2:0]};
   HOME_METHOD = m;
   // Load held over two falling edges, so the model meets it at one free of races
   repeat (2) @(negedge CLK);
   load = 1'H0;
   repeat (4) @(negedge CLK);
   exp_q.push_back(e);
   HOME_ENABLE = 1'H1;
   for (n = 0; n < 3000 && (HOMING_DONE | METHOD_ERROR) !== 1'H1; n++)
      @(negedge CLK);
   if (n == 3000)
   begin
      bad_count++;
      exp_q.delete();
      $display("Error at %0t: method %0d never finished", $time, m);
   end
   HOME_ENABLE = 1'H0;
   repeat (6) @(negedge CLK);
endtask
// Limit-and-reference methods also run mirrored about the window centre
task pair(input logic [3:0] m, input logic [15:0] s, input logic [15:0] e);
   run(m, s, e);
   run(m + 4'H4, 16'H07D0 - s, 16'H07D0 - e);
endtask
////////////////////////////////////////////////////////////
// Result watcher: oldest note against the index where the axis stopped
always @(negedge CLK)
begin
   if ((HOMING_DONE | METHOD_ERROR) === 1'H1 && !done_prev && exp_q.size() > 0)
      cmp(METHOD_ERROR === 1'H1 ? 16'HFFFF : last_idx, exp_q.pop_front());
   done_prev <= (HOMING_DONE | METHOD_ERROR) === 1'H1;
end
// Hang guard well above the longest expected run
always @(posedge CLK)
begin
   cycles++;
   if (cycles == 60000)
   begin
      bad_count++;
      $display("Error at %0t: run time limit reached", $time);
      conclude;
   end
end
initial
begin
   repeat (5) @(negedge CLK);
   RESET = 1'H0;
   cmp({10'H000, STOP_REQ, MOVE_ACTIVE, MOVE_POSITIVE, SPEED_FAST, HOMING_DONE,
      METHOD_ERROR}, 16'H0020);
   run(1, 1000, 200);
   run(1, 100, 200);
   run(2, 1000, 1800);
   run(2, 1900, 1800);
   run(3, 500, 900);
   run(3, 1000, 900);
   run(4, 500, 1100);
   run(4, 1000, 1000);
   run(5, 1000, 1100);
   run(5, 1500, 1100);
   run(6, 1000, 900);
   run(6, 1500, 1000);
   pair(7, 500, 900);
   pair(7, 1000, 900);
   pair(7, 1500, 900);
   pair(8, 500, 1000);
   pair(8, 1000, 1000);
   pair(8, 1500, 1000);
   pair(9, 500, 1000);
   pair(9, 1000, 1000);
   pair(9, 1500, 1000);
   pair(10, 500, 1100);
   pair(10, 1000, 1100);
   pair(10, 1500, 1100);
   run(0, 1000, 16'HFFFF);
   run(15, 1000, 16'HFFFF);
   conclude;
end
endmodule
`default_nettype wire
